// file: core/flash_bus_cycle.sv
// One write or read cycle on the flash pins, write-enable controlled
`timescale 1ns/1ps
module flash_bus_cycle (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic clk_en_in,
    // Cycle request
    input wire logic start_in,
    input wire logic write_in,
    input wire logic [flash_host_pkg::ADDR_W-1:0] addr_in,
    input wire logic [flash_host_pkg::DATA_W-1:0] wdata_in,
    output logic done_out,
    output logic [flash_host_pkg::DATA_W-1:0] rdata_out,
    // Flash pins
    input wire logic [flash_host_pkg::DATA_W-1:0] dq_in,
    output flash_host_pkg::flash_pins_type pins_out
);
    import flash_host_pkg::*;

    typedef enum logic [1:0] {B_IDLE, B_SETUP, B_STROBE, B_RECOVER} bus_state_type;

    bus_state_type state_reg;
    logic write_reg;
    logic [BUS_CNT_W-1:0] cnt_reg;
    logic [DATA_W-1:0] sync1_reg, sync2_reg, sync3_reg;
    logic sample_ok;
    logic wp_end;
    logic wph_end;

    assign sample_ok = !write_reg && (cnt_reg >= ACC_CYCLES + SYNC_LATENCY)
                       && (sync2_reg == sync3_reg);
    assign wp_end = write_reg && (cnt_reg == WP_CYCLES - 6'h01);
    assign wph_end = cnt_reg == WPH_CYCLES - 6'h01;

    ////////////////////////////////////////////////////////////////////////
    // Pin data resynchronisation; only the later stages are compared
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            sync3_reg <= '0;
        end else if (clk_en_in) begin
            sync1_reg <= dq_in;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            state_reg <= B_IDLE;
            write_reg <= 1'b0;
            cnt_reg <= '0;
        end else if (clk_en_in) begin
            case (state_reg)
                B_IDLE: begin
                    cnt_reg <= '0;
                    if (start_in) begin
                        write_reg <= write_in;
                        state_reg <= B_SETUP;
                    end
                end
                B_SETUP: begin
                    state_reg <= B_STROBE;
                end
                B_STROBE: begin
                    if (wp_end || sample_ok) begin
                        cnt_reg <= '0;
                        state_reg <= B_RECOVER;
                    end else if (cnt_reg != '1) begin
                        cnt_reg <= cnt_reg + 6'h01;
                    end
                end
                default: begin
                    cnt_reg <= cnt_reg + 6'h01;
                    if (wph_end) begin
                        state_reg <= B_IDLE;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin drive: address settles with chip enable a cycle before the strobe
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            pins_out.addr <= '0;
            pins_out.dq <= '0;
            pins_out.dq_oe_n <= 1'b1;
            pins_out.ce_n <= 1'b1;
            pins_out.we_n <= 1'b1;
            pins_out.oe_n <= 1'b1;
        end else if (clk_en_in) begin
            case (state_reg)
                B_IDLE: begin
                    if (start_in) begin
                        pins_out.addr <= addr_in;
                        pins_out.dq <= wdata_in;
                        pins_out.dq_oe_n <= !write_in;
                        pins_out.ce_n <= 1'b0;
                    end
                end
                B_SETUP: begin
                    // [RL14] Address latch edge
                    pins_out.we_n <= !write_reg;
                    pins_out.oe_n <= write_reg;
                end
                B_STROBE: begin
                    // [RL14] Data latch edge
                    if (wp_end || sample_ok) begin
                        pins_out.we_n <= 1'b1;
                        pins_out.oe_n <= 1'b1;
                    end
                end
                default: begin
                    // Data held one cycle past the rising strobe
                    pins_out.ce_n <= 1'b1;
                    pins_out.dq_oe_n <= 1'b1;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            done_out <= 1'b0;
            rdata_out <= '0;
        end else if (clk_en_in) begin
            done_out <= (state_reg == B_RECOVER) && wph_end;
            if (state_reg == B_STROBE && sample_ok) begin
                rdata_out <= sync3_reg;
            end
        end
    end

endmodule

// file: core/flash_cmd_host.sv
// Host sequencer issuing signature reads, whole array erase and reset to the flash
`timescale 1ns/1ps
module flash_cmd_host (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic clk_en_in,
    // Command port
    input wire logic cmd_valid_in,
    input flash_host_pkg::host_cmd_type cmd_in,
    output logic cmd_ready_out,
    output logic done_out,
    output logic [flash_host_pkg::DATA_W-1:0] result_out,
    // Flash pins
    input wire logic [flash_host_pkg::DATA_W-1:0] dq_in,
    output flash_host_pkg::flash_pins_type pins_out
);
    import flash_host_pkg::*;

    typedef enum logic [3:0] {
        S_IDLE, S_WRITE, S_WR_WAIT, S_READ, S_RD_WAIT,
        S_EXIT, S_EX_WAIT, S_HOLD, S_DONE
    } host_state_type;

    host_state_type state_reg;
    op_type op_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [STEP_W-1:0] step_reg;
    logic [CNT_W-1:0] hold_cnt_reg, hold_limit_reg, since_wr_reg;
    logic bus_start_reg, bus_write_reg;
    logic [ADDR_W-1:0] bus_addr_reg;
    logic [DATA_W-1:0] bus_data_reg;
    logic bus_done;
    logic [DATA_W-1:0] bus_rdata;

    function automatic logic is_ident(input op_type op);
        return op == OP_READ_MAKER || op == OP_READ_DEVICE || op == OP_READ_PROTECT;
    endfunction

    function automatic logic [STEP_W-1:0] write_count(input op_type op);
        if (op == OP_ERASE_ALL) begin
            return ERASE_WRITES;
        end else if (is_ident(op)) begin
            return IDENT_WRITES;
        end
        return '0;
    endfunction

    // Address and data of each write in an unlocked command sequence
    function automatic logic [ADDR_W+DATA_W-1:0] seq_word(input op_type op,
                                                        input logic [STEP_W-1:0] step);
        // [RL1] [RL7] [RL8] Command word placement
        case (step)
            3'h0, 3'h3: return {UNLOCK_ADDR_1, UNLOCK_DATA_1};
            3'h1, 3'h4: return {UNLOCK_ADDR_2, UNLOCK_DATA_2};
            3'h2: return (op == OP_ERASE_ALL) ? {CMD_ADDR, erase_setup_cmd}
                                              : {CMD_ADDR, read_identity_cmd};
            default: return {CMD_ADDR, whole_array_erase_cmd};
        endcase
    endfunction

    function automatic logic [ADDR_W-1:0] read_addr(input op_type op,
                                                    input logic [ADDR_W-1:0] addr);
        // [RL5] Sector on upper bits
        case (op)
            OP_READ_MAKER: return ID_MAKER_ADDR;
            OP_READ_DEVICE: return ID_DEVICE_ADDR;
            OP_READ_PROTECT: return {addr[SECTOR_MSB:SECTOR_LSB],
                                     ID_PROTECT_ADDR[SECTOR_LSB-1:0]};
            default: return addr;
        endcase
    endfunction

    flash_bus_cycle bus_cycle (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .clk_en_in(clk_en_in),
        .start_in(bus_start_reg),
        .write_in(bus_write_reg),
        .addr_in(bus_addr_reg),
        .wdata_in(bus_data_reg),
        .done_out(bus_done),
        .rdata_out(bus_rdata),
        .dq_in(dq_in),
        .pins_out(pins_out)
    );

    ////////////////////////////////////////////////////////////////////////
    // Command sequencing
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            state_reg <= S_IDLE;
            op_reg <= OP_READ_ARRAY;
            addr_reg <= '0;
            step_reg <= '0;
            hold_limit_reg <= '0;
            bus_start_reg <= 1'b0;
            bus_write_reg <= 1'b0;
            bus_addr_reg <= '0;
            bus_data_reg <= '0;
            cmd_ready_out <= 1'b1;
            done_out <= 1'b0;
            result_out <= '0;
        end else if (clk_en_in) begin
            bus_start_reg <= 1'b0;
            done_out <= 1'b0;
            case (state_reg)
                S_IDLE: begin
                    if (cmd_valid_in) begin
                        op_reg <= cmd_in.op;
                        addr_reg <= cmd_in.addr;
                        step_reg <= '0;
                        cmd_ready_out <= 1'b0;
                        if (write_count(cmd_in.op) != '0) begin
                            state_reg <= S_WRITE;
                        end else if (cmd_in.op == OP_RESET) begin
                            state_reg <= S_EXIT;
                        end else begin
                            state_reg <= S_READ;
                        end
                    end
                end
                S_WRITE: begin
                    // [RL13] Unlock pairs and command words
                    bus_start_reg <= 1'b1;
                    bus_write_reg <= 1'b1;
                    {bus_addr_reg, bus_data_reg} <= seq_word(op_reg, step_reg);
                    state_reg <= S_WR_WAIT;
                end
                S_WR_WAIT: begin
                    if (bus_done) begin
                        if (step_reg == write_count(op_reg) - 3'h1) begin
                            // [RL12] Settle before the first status read
                            hold_limit_reg <= STATUS_CYCLES;
                            state_reg <= (op_reg == OP_ERASE_ALL) ? S_HOLD : S_READ;
                        end else begin
                            step_reg <= step_reg + 3'h1;
                            state_reg <= S_WRITE;
                        end
                    end
                end
                S_READ: begin
                    // [RL2] Signature selection on the read address
                    bus_start_reg <= 1'b1;
                    bus_write_reg <= 1'b0;
                    bus_addr_reg <= read_addr(op_reg, addr_reg);
                    state_reg <= S_RD_WAIT;
                end
                S_RD_WAIT: begin
                    if (bus_done) begin
                        result_out <= bus_rdata;
                        // [RL16] Poll until the erase reports finished
                        if (op_reg == OP_ERASE_ALL && !bus_rdata[polling_status_bit]) begin
                            state_reg <= S_READ;
                        end else if (is_ident(op_reg)) begin
                            // [RL17] Leave signature mode explicitly
                            state_reg <= S_EXIT;
                        end else begin
                            state_reg <= S_DONE;
                        end
                    end
                end
                S_EXIT: begin
                    // [RL15] Single reset write
                    bus_start_reg <= 1'b1;
                    bus_write_reg <= 1'b1;
                    bus_addr_reg <= CMD_ADDR;
                    bus_data_reg <= reset_cmd;
                    state_reg <= S_EX_WAIT;
                end
                S_EX_WAIT: begin
                    if (bus_done) begin
                        hold_limit_reg <= RESET_CYCLES;
                        state_reg <= S_HOLD;
                    end
                end
                S_HOLD: begin
                    if (hold_cnt_reg == hold_limit_reg - 12'h001) begin
                        state_reg <= (op_reg == OP_ERASE_ALL) ? S_READ : S_DONE;
                    end
                end
                default: begin
                    done_out <= 1'b1;
                    cmd_ready_out <= 1'b1;
                    state_reg <= S_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wait counters; the trailing one times every gap after a write
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            hold_cnt_reg <= '0;
            since_wr_reg <= '0;
        end else if (clk_en_in) begin
            hold_cnt_reg <= (state_reg == S_HOLD) ? hold_cnt_reg + 12'h001 : '0;
            if (bus_done && bus_write_reg) begin
                since_wr_reg <= '0;
            end else if (since_wr_reg != '1) begin
                since_wr_reg <= since_wr_reg + 12'h001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);

    unlock_first_a: assert property ( // [RL13]
        bus_start_reg && bus_write_reg && op_reg != OP_RESET && step_reg == 3'h0
        |-> bus_addr_reg == UNLOCK_ADDR_1 && bus_data_reg == UNLOCK_DATA_1)
        else $error("first unlock write wrong");

    unlock_second_a: assert property ( // [RL13]
        bus_start_reg && bus_write_reg && state_reg == S_WR_WAIT
        && (step_reg == 3'h1 || step_reg == 3'h4)
        |-> bus_addr_reg == UNLOCK_ADDR_2 && bus_data_reg == UNLOCK_DATA_2)
        else $error("second unlock write wrong");

    ident_entry_a: assert property ( // [RL1]
        bus_start_reg && !bus_write_reg && is_ident(op_reg)
        |-> step_reg == IDENT_WRITES - 3'h1 && $past(bus_data_reg, 1) == read_identity_cmd)
        else $error("signature read without entry command");

    erase_setup_a: assert property ( // [RL7]
        bus_start_reg && bus_write_reg && op_reg == OP_ERASE_ALL && step_reg == 3'h2
        |-> bus_addr_reg == CMD_ADDR && bus_data_reg == erase_setup_cmd)
        else $error("erase setup write wrong");

    erase_confirm_a: assert property ( // [RL8]
        bus_start_reg && bus_write_reg && op_reg == OP_ERASE_ALL && step_reg == 3'h5
        |-> bus_addr_reg == CMD_ADDR && bus_data_reg == whole_array_erase_cmd)
        else $error("erase confirm write wrong");

    protect_addr_a: assert property ( // [RL5]
        bus_start_reg && !bus_write_reg && op_reg == OP_READ_PROTECT
        |-> !bus_addr_reg[ID_SEL_BIT0] && bus_addr_reg[ID_SEL_BIT1]
            && !bus_addr_reg[ID_SEL_BIT6]
            && bus_addr_reg[SECTOR_MSB:SECTOR_LSB] == addr_reg[SECTOR_MSB:SECTOR_LSB])
        else $error("protect query address wrong");

    status_wait_a: assert property ( // [RL12]
        bus_start_reg && !bus_write_reg && op_reg == OP_ERASE_ALL
        |-> since_wr_reg >= STATUS_CYCLES)
        else $error("status polled too early");

    reset_wait_a: assert property ( // [RL15]
        $rose(done_out) && (op_reg == OP_RESET || is_ident(op_reg))
        |-> since_wr_reg >= RESET_CYCLES)
        else $error("reset settle too short");

    erase_done_a: assert property ( // [RL16]
        $rose(done_out) && op_reg == OP_ERASE_ALL |-> result_out[polling_status_bit])
        else $error("erase finished without polling bit set");

endmodule

// file: core/flash_host_pkg.sv
// Constants and types shared by the flash command host and its pin cycle engine
// Operation
// [RL1] Unlock pair then 90h enters signature mode
// [RL2] Signature reads select by address bits
// [RL3] Bits 0,1,6 low read maker code
// [RL4] Bit 0 high reads device code
// [RL5] Protect query: bit1 high, sector on 18:16
// [RL6] Protect query answers 01h or 00h
// [RL7] Third erase write is 80h at 5555h
// [RL8] Sixth erase write is 10h at 5555h
// [RL9] Bad sequence aborts back to array read
// [RL10] Device pre-programs 00h then erases to 0FFh
// [RL11] Reads after sixth write return status
// [RL12] No completion shown before 10 us
// [RL13] Unlock pair is AAh@5555h then 55h@2AAAh
// [RL14] Address on falling, data on rising strobe
// [RL15] F0h returns to array; wait 5 us
// [RL16] Polling bit 0 while erasing, 1 when done
// [RL17] Signature mode persists until reset command
package flash_host_pkg;

    localparam int ADDR_W = 19;
    localparam int DATA_W = 8;
    localparam int CNT_W = 12;
    localparam int BUS_CNT_W = 6;
    localparam int STEP_W = 3;

    // Clock and pin timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int T_WP_NS = 50;
    localparam int T_WPH_NS = 20;
    localparam int T_ACC_NS = 150;
    localparam int T_STATUS_US = 10;
    localparam int T_RESET_US = 5;
    localparam logic [BUS_CNT_W-1:0] WP_CYCLES =
        BUS_CNT_W'((T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [BUS_CNT_W-1:0] WPH_CYCLES =
        BUS_CNT_W'((T_WPH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [BUS_CNT_W-1:0] ACC_CYCLES =
        BUS_CNT_W'((T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [BUS_CNT_W-1:0] SYNC_LATENCY = 6'h02;
    localparam logic [CNT_W-1:0] STATUS_CYCLES =
        CNT_W'((T_STATUS_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] RESET_CYCLES =
        CNT_W'((T_RESET_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Command words and addresses
    localparam logic [ADDR_W-1:0] UNLOCK_ADDR_1 = 19'h05555;
    localparam logic [ADDR_W-1:0] UNLOCK_ADDR_2 = 19'h02aaa;
    localparam logic [ADDR_W-1:0] CMD_ADDR = 19'h05555;
    localparam logic [DATA_W-1:0] UNLOCK_DATA_1 = 8'haa;
    localparam logic [DATA_W-1:0] UNLOCK_DATA_2 = 8'h55;
    localparam logic [DATA_W-1:0] read_identity_cmd = 8'h90;
    localparam logic [DATA_W-1:0] erase_setup_cmd = 8'h80;
    localparam logic [DATA_W-1:0] whole_array_erase_cmd = 8'h10;
    localparam logic [DATA_W-1:0] reset_cmd = 8'hf0;
    localparam logic [DATA_W-1:0] SECTOR_PROTECTED = 8'h01;
    localparam logic [STEP_W-1:0] IDENT_WRITES = 3'h3;
    localparam logic [STEP_W-1:0] ERASE_WRITES = 3'h6;

    // Signature address selection
    localparam logic [ADDR_W-1:0] ID_MAKER_ADDR = 19'h00000;
    localparam logic [ADDR_W-1:0] ID_DEVICE_ADDR = 19'h00001;
    localparam logic [ADDR_W-1:0] ID_PROTECT_ADDR = 19'h00002;
    localparam int ID_SEL_BIT0 = 0;
    localparam int ID_SEL_BIT1 = 1;
    localparam int ID_SEL_BIT6 = 6;
    localparam int SECTOR_LSB = 16;
    localparam int SECTOR_MSB = 18;

    // Status bits
    localparam int polling_status_bit = 7;
    localparam int toggling_status_bit = 6;

    typedef enum logic [2:0] {
        OP_READ_ARRAY,
        OP_READ_MAKER,
        OP_READ_DEVICE,
        OP_READ_PROTECT,
        OP_ERASE_ALL,
        OP_RESET
    } op_type;

    typedef struct packed {
        op_type op;
        logic [ADDR_W-1:0] addr;
    } host_cmd_type;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dq;
        logic dq_oe_n;
        logic ce_n;
        logic we_n;
        logic oe_n;
    } flash_pins_type;

endpackage

// file: sim/flash_cmd_host_tb.sv
// Self-checking bench for the flash command host against a device model
`timescale 1ns/1ps
module flash_cmd_host_tb;
    import flash_host_pkg::*;

    localparam logic [7:0] MAKER = 8'h3c;
    localparam logic [7:0] DEVICE = 8'h7b;
    localparam logic [7:0] PROT = 8'h5a;

    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic clk_en_in = 1'b1;
    logic cmd_valid_in = 1'b0;
    host_cmd_type cmd_in = '0;
    logic cmd_ready_out;
    logic done_out;
    logic [7:0] result_out;
    flash_pins_type pins_out;
    logic [7:0] dq_wire;
    logic [7:0] dq_last = 8'h00;
    logic [7:0] mdq;
    logic mdrive;
    logic [7:0] exp_q[$];
    logic [31:0] seed = 32'h37a7;
    int n_errors = 0;
    int total_checks = 0;

    always #2 clk_in = ~clk_in;

    flash_cmd_host dut (
        .clk_in(clk_in), .reset_in(reset_in), .clk_en_in(clk_en_in),
        .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in), .cmd_ready_out(cmd_ready_out),
        .done_out(done_out), .result_out(result_out), .dq_in(dq_wire), .pins_out(pins_out));

    flash_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE), .PROTECT_MASK(PROT)) flash (
        .pins_in(pins_out), .bus_in(dq_wire), .dq_out(mdq), .drive_out(mdrive));

    // Released lines show the inverse of their last level, so stale data never matches
    assign dq_wire = !pins_out.dq_oe_n ? pins_out.dq : (mdrive ? mdq : ~dq_last);
    always @(posedge clk_in) dq_last <= dq_wire;

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [7:0] arr(input logic [18:0] a);
        return a[7:0] ^ a[15:8] ^ {5'h00, a[18:16]};
    endfunction

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Holds valid high between commands so back-to-back takes are exercised
    task automatic issue(input op_type op, input logic [18:0] a, input logic [7:0] exp);
        cmd_in <= '{op: op, addr: a};
        cmd_valid_in <= 1'b1;
        exp_q.push_back(exp);
        do @(posedge clk_in); while (!(clk_en_in && cmd_ready_out));
    endtask

    task automatic drain();
        cmd_valid_in <= 1'b0;
        wait (exp_q.size() == 0);
        @(posedge clk_in);
    endtask

    task automatic end_of_test();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk_in) begin
        logic [31:0] r;
        r = rnd();
        clk_en_in <= reset_in || r[2:0] != 3'h0;
    end

    always @(posedge clk_in) begin
        if (!pins_out.dq_oe_n && mdrive) check("dq_contention", 8'h00, 8'h01);
        if (clk_en_in && done_out === 1'b1) begin
            if (exp_q.size() == 0) check("done_out", 8'h00, 8'h01);
            else check("result_out", exp_q.pop_front(), result_out);
        end
    end

    initial begin
        logic [31:0] r;
        repeat (12) @(posedge clk_in);
        reset_in <= 1'b0;
        @(posedge clk_in);
        check("ce_n_idle", 8'h01, {7'h00, pins_out.ce_n});
        check("ready_idle", 8'h01, {7'h00, cmd_ready_out});
        for (int i = 0; i < 3; i++) begin
            r = rnd();
            issue(OP_READ_ARRAY, r[18:0], arr(r[18:0]));
        end
        issue(OP_READ_MAKER, 19'h00000, MAKER);
        issue(OP_READ_DEVICE, 19'h00000, DEVICE);
        for (int s = 0; s < 8; s++) begin
            r = rnd();
            issue(OP_READ_PROTECT, {s[2:0], r[15:0]}, {7'h00, PROT[s]});
        end
        r = rnd();
        issue(OP_READ_ARRAY, r[18:0], arr(r[18:0]));
        issue(OP_RESET, 19'h00000, arr(r[18:0]));
        drain();
        issue(OP_ERASE_ALL, r[18:0], 8'hff);
        drain();
        // First status poll must wait out the settle time after the confirm strobe
        r[0] = flash.first_poll - flash.busy_since >= T_STATUS_US * 1000.0;
        check("erase_wait", 8'h01, {7'h00, r[0]});
        check("status_polls", 8'h01, {7'h00, flash.busy_reads > 0});
        issue(OP_READ_ARRAY, r[18:0] ^ 19'h01234, 8'hff);
        drain();
        end_of_test();
    end

    initial begin
        #400000;
        check("watchdog", 8'h00, 8'h01);
        end_of_test();
    end
endmodule

// file: sim/flash_model.sv
// Behavioural flash device answering the host's pin cycles
`timescale 1ns/1ps
module flash_model #(
    // Identity codes are arbitrary
    parameter logic [7:0] MAKER_CODE = 8'h3c,
    parameter logic [7:0] DEVICE_CODE = 8'h7b,
    parameter logic [7:0] PROTECT_MASK = 8'ha5,
    parameter int ERASE_NS = 20000
) (
    // Host pins
    input wire flash_host_pkg::flash_pins_type pins_in,
    input wire logic [7:0] bus_in,
    // Data drive
    output logic [7:0] dq_out,
    output logic drive_out
);
    typedef enum logic [1:0] {MODE_ARRAY, MODE_SIG, MODE_BUSY} mode_type;
    mode_type mode = MODE_ARRAY;
    logic [2:0] step = 3'h0;
    logic erased = 1'b0;
    logic toggle = 1'b0;
    logic [18:0] lat_addr = 19'h00000;
    realtime busy_since = 0.0;
    realtime first_poll = 0.0;
    int busy_reads = 0;

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] read_byte(input logic [18:0] a, input mode_type m,
                                             input logic t, input logic e);
        if (m == MODE_BUSY) return {1'b0, t, 6'h00};
        if (m == MODE_SIG) begin
            if (a[6]) return 8'h00;
            case (a[1:0])
                2'b00: return MAKER_CODE;
                2'b01: return DEVICE_CODE;
                2'b10: return {7'h00, PROTECT_MASK[a[18:16]]};
                default: return 8'h00;
            endcase
        end
        return e ? 8'hff : a[7:0] ^ a[15:8] ^ {5'h00, a[18:16]};
    endfunction

    task automatic take_write(input logic [18:0] a, input logic [7:0] d);
        logic at_cmd;
        at_cmd = (a == 19'h05555);
        if (mode == MODE_BUSY) return;
        if (d == 8'hf0) begin
            mode = MODE_ARRAY;
            step = 3'h0;
            return;
        end
        case (step)
            3'h0, 3'h3: step = (at_cmd && d == 8'haa) ? step + 3'h1 : 3'h0;
            3'h1, 3'h4: step = (a == 19'h02aaa && d == 8'h55) ? step + 3'h1 : 3'h0;
            3'h2: begin
                if (at_cmd && d == 8'h90) mode = MODE_SIG;
                step = (at_cmd && d == 8'h80) ? 3'h3 : 3'h0;
            end
            default: begin
                if (at_cmd && d == 8'h10) begin
                    mode = MODE_BUSY;
                    busy_since = $realtime;
                end
                step = 3'h0;
            end
        endcase
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    assign drive_out = !pins_in.ce_n && !pins_in.oe_n && pins_in.we_n;
    assign dq_out = read_byte(pins_in.addr, mode, toggle, erased);

    always @(negedge pins_in.we_n) begin
        if (!pins_in.ce_n) lat_addr = pins_in.addr;
    end

    always @(posedge pins_in.we_n) begin
        if (!pins_in.ce_n) take_write(lat_addr, bus_in);
    end

    always @(negedge pins_in.oe_n) begin
        if (mode == MODE_BUSY && $realtime - busy_since >= ERASE_NS) begin
            mode = MODE_ARRAY;
            erased = 1'b1;
        end
        if (mode == MODE_BUSY) begin
            if (busy_reads == 0) first_poll = $realtime;
            toggle = ~toggle;
            busy_reads++;
        end
    end
endmodule
